// ### rtl/light_readout_pkg.sv
/*
 Types shared by the light result readout block.
 Assumes nothing of its surroundings.
*/
package light_readout_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WDATA,
        ST_RDATA,
        ST_GCALL,
        ST_SKIP
    } bus_state_t;
endpackage

// ### rtl/light_readout_regs.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 light result readout block. Assumes inclusion by bare name from rtl/.
*/
// Behaviour
// - Data-ready flag sets whenever a new light result is stored.
// - Data-ready flag clears after the host reads the high result byte.
// - Out-of-range measurement sets saturation flag: bit 1 light, bit 0 compensation.
// - Each finished conversion writes its 16-bit result into the register pair.
// - Reading the low byte freezes the high byte until it is read.
// - A byte takes nine clocks; a cut transfer holds the data line level.
// - General call followed by byte 0x06 performs a software reset.
// - Coming out of reset the device releases data; it never holds clock low.
// - Target answers at seven-bit address 0x38; direction bit 1 means read.
`ifndef LIGHT_READOUT_REGS_SVH
`define LIGHT_READOUT_REGS_SVH

`define TARGET_ADDR 7'h38
`define GCALL_ADDR 7'h00
`define GCALL_SWRESET 8'h06
`define REG_RESULT_STATUS 8'h17
`define REG_LIGHT_LOW 8'h1e
`define REG_LIGHT_HIGH 8'h1f
`define STAT_READY_BIT 7
`define STAT_LIGHT_SAT_BIT 1
`define STAT_COMP_SAT_BIT 0
`define RESULT_RESET 16'h0000
`define BYTE_CLOCKS 4'h9

`endif

// ### rtl/light_result_readout_i2c.sv
/*
 I2C target holding the light result pair and the data status register.
 Assumes a measurement engine on core_clk_i that pulses conv_done_i with
 the result and saturation levels, and open-drain pads with pull-ups.
*/
`timescale 1ns/1ps
`include "light_readout_regs.svh"
module light_result_readout_i2c (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic conv_done_i,
    input wire logic [15:0] light_result_word_i,
    input wire logic light_sat_i,
    input wire logic comp_sat_i,
    output logic soft_reset_o
);
    // ------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------
    logic scl, sda;
    pin_sync3 u_scl (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .pin_i(scl_i), .level_o(scl));
    pin_sync3 u_sda (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .pin_i(sda_i), .level_o(sda));

    logic scl_d_ff, sda_d_ff;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    assign scl_rise = scl & ~scl_d_ff;
    assign scl_fall = ~scl & scl_d_ff;
    assign start_cond = scl & scl_d_ff & sda_d_ff & ~sda;
    assign stop_cond = scl & scl_d_ff & ~sda_d_ff & sda;

    // ------------------------------------------------------------
    // Register and protocol state
    // ------------------------------------------------------------
    light_readout_pkg::bus_state_t st_ff, nxt_st;
    logic [3:0] bit_ff, nxt_bit;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] ptr_ff, nxt_ptr;
    logic [7:0] tx_ff, nxt_tx;
    logic ack_ff, nxt_ack;
    logic rd_ff, nxt_rd;
    logic drive_low_ff, nxt_drive_low;
    logic [15:0] result_ff, nxt_result;
    logic [7:0] high_hold_ff, nxt_high_hold;
    logic hold_ff, nxt_hold;
    logic ready_ff, nxt_ready;
    logic lsat_ff, nxt_lsat;
    logic csat_ff, nxt_csat;
    logic swrst_ff, nxt_swrst;

    function automatic logic [7:0] read_reg(input logic [7:0] a,
        input logic [15:0] r, input logic [7:0] hh, input logic h,
        input logic rdy, input logic ls, input logic cs);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `REG_RESULT_STATUS: begin
                v[`STAT_READY_BIT] = rdy;
                v[`STAT_LIGHT_SAT_BIT] = ls;
                v[`STAT_COMP_SAT_BIT] = cs;
            end
            `REG_LIGHT_LOW: v = r[7:0];
            `REG_LIGHT_HIGH: v = h ? hh : r[15:8];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_bit = bit_ff;
        nxt_shift = shift_ff;
        nxt_ptr = ptr_ff;
        nxt_tx = tx_ff;
        nxt_ack = ack_ff;
        nxt_rd = rd_ff;
        nxt_drive_low = drive_low_ff;
        nxt_result = result_ff;
        nxt_high_hold = high_hold_ff;
        nxt_hold = hold_ff;
        nxt_ready = ready_ff;
        nxt_lsat = lsat_ff;
        nxt_csat = csat_ff;
        nxt_swrst = 1'h0;

        // Clears come first so a same-cycle new result wins
        if (scl_fall && st_ff == light_readout_pkg::ST_RDATA &&
            bit_ff == 4'h8 && rd_ff) begin
            if (ptr_ff == `REG_LIGHT_LOW) begin
                nxt_high_hold = result_ff[15:8];
                nxt_hold = 1'h1;
            end else if (ptr_ff == `REG_LIGHT_HIGH) begin
                nxt_hold = 1'h0;
                nxt_ready = 1'h0;
            end
        end
        if (conv_done_i) begin
            nxt_result = light_result_word_i;
            nxt_ready = 1'h1;
            nxt_lsat = light_sat_i;
            nxt_csat = comp_sat_i;
        end

        if (start_cond) begin
            nxt_st = light_readout_pkg::ST_ADDR;
            // The START's own SCL fall must not count as a data bit:
            // it wraps the counter to zero before the first bit
            nxt_bit = 4'hf;
            nxt_drive_low = 1'h0;
        end else if (stop_cond) begin
            nxt_st = light_readout_pkg::ST_IDLE;
            nxt_drive_low = 1'h0;
        end else if (st_ff != light_readout_pkg::ST_IDLE &&
                     st_ff != light_readout_pkg::ST_SKIP) begin
            // Line only changes on SCL low; a short transfer just waits
            if (scl_rise && bit_ff < 4'h8) begin
                nxt_shift = {shift_ff[6:0], sda};
            end
            if (scl_rise && bit_ff == 4'h8) begin
                nxt_ack = ~sda; // Host ACK on reads
            end
            if (scl_fall) begin
                nxt_bit = bit_ff + 4'h1;
                if (bit_ff == 4'h7) begin
                    // Ninth clock: acknowledge slot
                    nxt_drive_low = 1'h0;
                    case (st_ff)
                        light_readout_pkg::ST_ADDR: begin
                            if (shift_ff[7:1] == `TARGET_ADDR) begin
                                nxt_drive_low = 1'h1;
                                nxt_rd = shift_ff[0];
                            end else if (shift_ff == 8'h00) begin
                                nxt_drive_low = 1'h1;
                                nxt_rd = 1'h0;
                            end else begin
                                nxt_st = light_readout_pkg::ST_SKIP;
                            end
                        end
                        light_readout_pkg::ST_RDATA: nxt_drive_low = 1'h0;
                        default: nxt_drive_low = 1'h1;
                    endcase
                end else if (bit_ff == 4'h8) begin
                    nxt_bit = 4'h0;
                    nxt_drive_low = 1'h0;
                    case (st_ff)
                        light_readout_pkg::ST_ADDR: begin
                            if (shift_ff == 8'h00) begin
                                nxt_st = light_readout_pkg::ST_GCALL;
                            end else if (rd_ff) begin
                                nxt_st = light_readout_pkg::ST_RDATA;
                                nxt_tx = read_reg(ptr_ff, result_ff,
                                    high_hold_ff, hold_ff, ready_ff,
                                    lsat_ff, csat_ff);
                                nxt_drive_low = ~nxt_tx[7];
                            end else begin
                                nxt_st = light_readout_pkg::ST_REG;
                            end
                        end
                        light_readout_pkg::ST_REG: begin
                            nxt_ptr = shift_ff;
                            nxt_st = light_readout_pkg::ST_WDATA;
                        end
                        light_readout_pkg::ST_WDATA: begin
                            // All held registers are read-only
                            nxt_ptr = ptr_ff + 8'h01;
                        end
                        light_readout_pkg::ST_GCALL: begin
                            if (shift_ff == `GCALL_SWRESET) begin
                                nxt_swrst = 1'h1;
                            end
                            nxt_st = light_readout_pkg::ST_SKIP;
                        end
                        light_readout_pkg::ST_RDATA: begin
                            if (ack_ff) begin
                                nxt_tx = read_reg(nxt_ptr + 8'h01,
                                    nxt_result, nxt_high_hold, nxt_hold,
                                    nxt_ready, nxt_lsat, nxt_csat);
                                nxt_ptr = ptr_ff + 8'h01;
                                nxt_drive_low = ~nxt_tx[7];
                            end else begin
                                nxt_st = light_readout_pkg::ST_SKIP;
                            end
                        end
                        default: nxt_st = light_readout_pkg::ST_SKIP;
                    endcase
                end else if (st_ff == light_readout_pkg::ST_RDATA) begin
                    nxt_tx = {tx_ff[6:0], 1'h0};
                    nxt_drive_low = ~tx_ff[6];
                end
            end
        end

        if (swrst_ff) begin
            // Programmable state returns to its reset values
            nxt_result = `RESULT_RESET;
            nxt_ready = 1'h0;
            nxt_lsat = 1'h0;
            nxt_csat = 1'h0;
            nxt_hold = 1'h0;
            nxt_ptr = 8'h00;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_d_ff <= 1'h1;
            sda_d_ff <= 1'h1;
            st_ff <= light_readout_pkg::ST_IDLE;
            bit_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 8'h00;
            tx_ff <= 8'h00;
            ack_ff <= 1'h0;
            rd_ff <= 1'h0;
            drive_low_ff <= 1'h0;
            result_ff <= `RESULT_RESET;
            high_hold_ff <= 8'h00;
            hold_ff <= 1'h0;
            ready_ff <= 1'h0;
            lsat_ff <= 1'h0;
            csat_ff <= 1'h0;
            swrst_ff <= 1'h0;
        end else begin
            scl_d_ff <= scl;
            sda_d_ff <= sda;
            st_ff <= nxt_st;
            bit_ff <= nxt_bit;
            shift_ff <= nxt_shift;
            ptr_ff <= nxt_ptr;
            tx_ff <= nxt_tx;
            ack_ff <= nxt_ack;
            rd_ff <= nxt_rd;
            drive_low_ff <= nxt_drive_low;
            result_ff <= nxt_result;
            high_hold_ff <= nxt_high_hold;
            hold_ff <= nxt_hold;
            ready_ff <= nxt_ready;
            lsat_ff <= nxt_lsat;
            csat_ff <= nxt_csat;
            swrst_ff <= nxt_swrst;
        end
    end

    // Open drain: only ever pulls low; enable is active low
    assign sda_o = 1'h0;
    assign sda_oe_n_o = ~drive_low_ff;
    assign soft_reset_o = swrst_ff;
endmodule

// ### rtl/pin_sync3.sv
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes the pin is asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
module pin_sync3 (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic pin_i,
    output logic level_o
);
    logic s1_ff, s2_ff, s3_ff, lvl_ff;
    logic nxt_lvl;

    // A change counts once stages two and three agree; bus idles high
    always_comb begin
        nxt_lvl = lvl_ff;
        if (s2_ff == s3_ff) begin
            nxt_lvl = s3_ff;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_ff <= 1'h1;
            s2_ff <= 1'h1;
            s3_ff <= 1'h1;
            lvl_ff <= 1'h1;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign level_o = lvl_ff;
endmodule

// ### tb/i2c_host.sv
/*
 Behavioural I2C host controller.
 Assumes pull-ups: a released line is driven high here.
*/
`timescale 1ns/1ps
module i2c_host (
    output logic scl_o,
    output logic sda_o,
    input wire logic sda_i
);
    // Quarter bit; faster than the bus allows to keep the run short,
    // still far above the 40 ns SCL low the target needs
    localparam int Q = 60;
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end
    task automatic start();
        sda_o = 1'h1;
        #Q scl_o = 1'h1;
        #Q sda_o = 1'h0;
        #Q scl_o = 1'h0;
        #Q;
    endtask
    task automatic stop();
        sda_o = 1'h0;
        #Q scl_o = 1'h1;
        #Q sda_o = 1'h1;
        #Q;
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        #Q scl_o = 1'h1;
        #Q r = sda_i;
        #Q scl_o = 1'h0;
        #Q;
    endtask
    task automatic xfer(input logic [7:0] w, input logic ack_in,
                        output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(w[i], r[i]);
        end
        bit_io(ack_in, ack);
    endtask
    task automatic pulses(input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            bit_io(1'h1, d);
        end
    endtask
endmodule

// ### tb/light_readout_checker_assertions.sv
/*
 Port checker for the light result readout target.
 Assumes a bind to light_result_readout_i2c and pull-ups on SCL and SDA.
*/
`timescale 1ns/1ps
`include "light_readout_regs.svh"
module light_readout_checker (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic conv_done_i,
    input wire logic soft_reset_o
);
    // ----------------
    // Drive run length
    // ----------------
    // Raw SCL rises while SDA is held low: ACK plus 8 data bits at most
    logic scl_q_ff;
    logic nxt_scl_q;
    logic [3:0] run_ff;
    logic [3:0] nxt_run;
    always_comb begin
        nxt_scl_q = scl_i;
        nxt_run = run_ff;
        if (sda_oe_n_o) begin
            nxt_run = 4'h0;
        end else if (scl_i && !scl_q_ff && run_ff != 4'hf) begin
            nxt_run = run_ff + 4'h1;
        end
    end
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_q_ff <= 1'h1;
            run_ff <= 4'h0;
        end else begin
            scl_q_ff <= nxt_scl_q;
            run_ff <= nxt_run;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_OPEN_DRAIN: assert property (sda_o == 1'h0)
        else $error("SDA output value not low");
    AST_RESET_RELEASED: assert property ($rose(resetn_i) |->
        sda_oe_n_o && !soft_reset_o) else $error("bus held after reset");
    AST_SOFT_PULSE: assert property (soft_reset_o |=> !soft_reset_o)
        else $error("soft reset pulse too long");
    // Soft reset may drop a drive at once, so its two cycles are exempt
    AST_CHANGE_SCL_LOW: assert property ($changed(sda_oe_n_o) &&
        !$past(soft_reset_o) && !$past(soft_reset_o, 2) |-> !scl_i)
        else $error("SDA drive changed while SCL high");
    AST_DRIVE_AFTER_FALL: assert property ($fell(sda_oe_n_o) |->
        !scl_i && !$past(scl_i, 3)) else $error("drive not after SCL fall");
    AST_DRIVE_STANDS: assert property ($fell(sda_oe_n_o) |->
        !sda_oe_n_o [*4]) else $error("drive dropped early");
    AST_DRIVE_BOUND: assert property (run_ff <= `BYTE_CLOCKS)
        else $error("SDA held low past nine clocks");
    AST_CONV_BUS_QUIET: assert property (conv_done_i && scl_i &&
        sda_oe_n_o |=> sda_oe_n_o) else $error("result store moved SDA");
    COV_SOFT_RESET: cover property (soft_reset_o);
    COV_DRIVE_START: cover property ($fell(sda_oe_n_o));
    COV_LONG_RUN: cover property (run_ff == 4'h9);
endmodule
bind light_result_readout_i2c light_readout_checker u_light_readout_checker (
    .core_clk_i, .resetn_i, .scl_i, .sda_o, .sda_oe_n_o, .conv_done_i,
    .soft_reset_o
);

// ### tb/tb_light_result_readout_i2c.sv
/*
 Self-checking bench: result and status reads over I2C.
 Assumes i2c_host as bus host and pull-ups on both lines.
*/
`timescale 1ns/1ps
`include "light_readout_regs.svh"
module tb_light_result_readout_i2c;
    logic core_clk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic conv_done_i = 1'h0;
    logic [15:0] light_result_word_i = 16'h0000;
    logic light_sat_i = 1'h0;
    logic comp_sat_i = 1'h0;
    logic scl, host_sda, sda_o, sda_oe_n_o, soft_reset_o, a;
    logic [7:0] r;
    wire logic sda_w;
    int n_fail = 0;
    int checks_done = 0;
    int n_soft = 0;
    // Open drain: either party pulls low, pull-up otherwise
    assign sda_w = host_sda & (sda_oe_n_o | sda_o);
    always #2 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        if (soft_reset_o === 1'h1) begin
            n_soft++;
        end
    end
    light_result_readout_i2c u_light_result_readout_i2c (
        .core_clk_i, .resetn_i, .scl_i(scl), .sda_i(sda_w), .sda_o,
        .sda_oe_n_o, .conv_done_i, .light_result_word_i, .light_sat_i,
        .comp_sat_i, .soft_reset_o
    );
    i2c_host u_i2c_host (.scl_o(scl), .sda_o(host_sda), .sda_i(sda_w));
    // --------------
    // Access tasks
    // --------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic sel(input logic [7:0] ra);
        u_i2c_host.start();
        u_i2c_host.xfer({`TARGET_ADDR, 1'h0}, 1'h1, r, a);
        chk({7'h00, a}, 8'h00);
        u_i2c_host.xfer(ra, 1'h1, r, a);
        u_i2c_host.start();
        u_i2c_host.xfer({`TARGET_ADDR, 1'h1}, 1'h1, r, a);
    endtask
    task automatic rd(input logic [7:0] ra, input logic [15:0] e,
                      input logic two);
        sel(ra);
        u_i2c_host.xfer(8'hff, !two, r, a);
        chk(r, e[7:0]);
        if (two) begin
            u_i2c_host.xfer(8'hff, 1'h1, r, a);
            chk(r, e[15:8]);
        end
        u_i2c_host.stop();
    endtask
    task automatic wr(input logic [23:0] b, input int n, input logic ack);
        u_i2c_host.start();
        for (int k = 0; k < n; k++) begin
            u_i2c_host.xfer(b[23-8*k -: 8], 1'h1, r, a);
            if (k == 0) begin
                chk({7'h00, a}, {7'h00, ack});
            end
        end
        u_i2c_host.stop();
    endtask
    task automatic conv(input logic [15:0] w, input logic ls, input logic cs);
        light_result_word_i = w;
        light_sat_i = ls;
        comp_sat_i = cs;
        conv_done_i = 1'h1;
        @(posedge core_clk_i);
        #1;
        conv_done_i = 1'h0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk_i);
        #1;
        resetn_i = 1'h1;
        repeat (8) @(posedge core_clk_i);
        #1;
        chk({7'h00, sda_oe_n_o}, 8'h01);
        rd(`REG_RESULT_STATUS, 16'h0000, 1'h0);
        conv(16'ha5c3, 1'h1, 1'h0);
        rd(`REG_RESULT_STATUS, 16'h0082, 1'h0);
        rd(`REG_LIGHT_LOW, 16'h00c3, 1'h0);
        conv(16'h1234, 1'h0, 1'h1);
        rd(`REG_LIGHT_HIGH, 16'h00a5, 1'h0);
        rd(`REG_RESULT_STATUS, 16'h0001, 1'h0);
        wr({`TARGET_ADDR, 1'h0, `REG_RESULT_STATUS, 8'hff}, 3, 1'h0);
        rd(`REG_RESULT_STATUS, 16'h0001, 1'h0);
        rd(`REG_LIGHT_LOW, 16'h1234, 1'h1);
        wr({7'h39, 1'h0, 16'h0000}, 1, 1'h1);
        sel(`REG_LIGHT_LOW);
        u_i2c_host.pulses(3);
        a = sda_oe_n_o;
        #2000;
        chk({7'h00, sda_oe_n_o}, {7'h00, a});
        u_i2c_host.pulses(9);
        u_i2c_host.stop();
        rd(`REG_LIGHT_LOW, 16'h1234, 1'h1);
        wr({`GCALL_ADDR, 1'h0, `GCALL_SWRESET, 8'h00}, 2, 1'h0);
        chk(n_soft[7:0], 8'h01);
        rd(`REG_RESULT_STATUS, 16'h0000, 1'h0);
        tally_and_finish();
    end
    // Tests need about 114 us; 350 us means a hang and stays short
    initial begin
        #350000;
        n_fail++;
        tally_and_finish();
    end
endmodule
